// file: common/wdt_defines.svh
// Contract
// - taking an interrupt pushes only the return address; no context saved
// - top 16 data locations of every bank map to one shared area
// - watchdog counts on its own free-running RC oscillator, also in sleep
// - watchdog timeout outside sleep causes a full watchdog reset
// - watchdog timeout during sleep wakes the device and execution continues
// - every watchdog timeout clears the active-low expired flag, status bit 4
// - watchdog is disabled for good while its enable fuse reads zero
// - shared prescaler acts as watchdog postscaler when assign bit selects it
// - kick or sleep instruction clears watchdog counter and its postscaler
// - kick instruction leaves the prescaler assignment untouched
// - sleep entry clears watchdog, clears power-down, sets expired, stops osc
// - pins hold their pre-sleep state for the whole sleep
// - wake on reset pin, watchdog or enabled interrupt; only pin resets
// - power-down flag set at power-up; expired flag cleared on watchdog wake
// - only clock-free peripherals may raise wake interrupts during sleep
// - enabled source wakes regardless of global enable
// - after interrupt wake vector only when global enable is set
// - sleep with enabled flag already pending acts as no operation
// - interrupt arriving once asleep: sleep effects first, then wake
// - debug fuse at zero enables debug and reserves pins and one stack level
// - program verify readout allowed only with code protection unprogrammed
// - four ID words usable only in program mode; low four bits advised
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

`define WDT_IDX_STATUS 14'h0003
`define WDT_IDX_OPTION 14'h0081
`define WDT_IDX_ID_BASE 14'h2000
`define WDT_IDX_FUSE 14'h2007
`define WDT_ID_COUNT 4

`define WDT_OPT_PSA_BIT 3
`define WDT_OPT_PS_MSB 2
`define WDT_OPT_RESET 8'hFF

`define WDT_FUSE_WATCHDOG_ENABLE_FUSE_BIT 2
`define WDT_FUSE_CP0_BIT 4
`define WDT_FUSE_CP1_BIT 5
`define WDT_FUSE_DEBUG_BIT 7
`define WDT_FUSE_RESET 8'hFF

`define WDT_STAT_PD_BIT 3
`define WDT_STAT_TO_BIT 4

`define WDT_COMMON_BASE 7'h70
`define WDT_STACK_LEVELS 4'h8
`define WDT_STACK_LEVELS_DEBUG 4'h7

`endif

// file: common/wdt_types_pkg.sv
package wdt_types_pkg;
  typedef enum logic [0:0] {
    RUN_ST,
    SLEEP_ST
  } power_state_type;
endpackage

// file: rtl/watchdog_sleep_wake_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "wdt_defines.svh"
module watchdog_sleep_wake_control #(
  parameter int WDT_BASE_TICKS = 256,
  parameter int IRQ_COUNT = 8,
  parameter logic [IRQ_COUNT-1:0] SLEEP_WAKE_CAPABLE = '1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [15:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic rc_osc_i,
  input wire logic master_reset_pin_n_i,
  input wire logic kick_watchdog_instr_i,
  input wire logic sleep_instr_i,
  input wire logic irq_taken_i,
  input wire logic [IRQ_COUNT-1:0] irq_flags_i,
  input wire logic [IRQ_COUNT-1:0] irq_enables_i,
  input wire logic global_irq_enable_i,
  input wire logic prog_mode_i,
  input wire logic [8:0] data_addr_i,
  output logic device_reset_o,
  output logic wake_o,
  output logic vector_after_wake_o,
  output logic osc_drive_en_o,
  output logic io_hold_o,
  output wdt_types_pkg::power_state_type power_state_o,
  output logic stack_push_o,
  output logic [8:0] data_phys_o,
  output logic watchdog_expired_flag_n_o,
  output logic sleep_entered_flag_n_o,
  output logic verify_read_allowed_o,
  output logic debug_enabled_o,
  output logic [3:0] stack_levels_o
);
  import wdt_types_pkg::*;

  localparam int BW = (WDT_BASE_TICKS > 1) ? $clog2(WDT_BASE_TICKS) : 1;
  localparam logic [BW-1:0] BASE_LAST = BW'(WDT_BASE_TICKS - 1);

  typedef struct packed {
    power_state_type st;
    logic osc_s1;
    logic osc_s2;
    logic osc_s3;
    logic osc_lvl;
    logic osc_prev;
    logic master_reset_pin_n_s1;
    logic master_reset_pin_n_s2;
    logic master_reset_pin_n_s3;
    logic master_reset_pin_n_lvl;
    logic [BW-1:0] base_cnt;
    logic [7:0] post_cnt;
    logic to_n;
    logic pd_n;
    logic [7:0] option;
    logic [7:0] fuse;
    logic [3:0][7:0] id;
    logic ack;
    logic [31:0] dat;
    logic dev_rst;
    logic wake;
    logic vector;
    logic push;
    logic [8:0] phys;
    logic verify_ok;
  } state_type;

  state_type s;
  state_type next_s;

  // ==========================================================
  // watchdog timebase decode
  // ==========================================================
  logic tick;
  logic wdt_en;
  logic prescaler_assign;
  logic [7:0] ratio_last;
  logic base_done;
  logic timeout;
  logic pend_any;
  logic pend_wake;
  logic sleep_go;
  logic bus_wr;
  logic [13:0] idx;
  logic id_hit;

  always_comb begin
    tick = s.osc_lvl & ~s.osc_prev;
    wdt_en = s.fuse[`WDT_FUSE_WATCHDOG_ENABLE_FUSE_BIT];
    prescaler_assign = s.option[`WDT_OPT_PSA_BIT];
    ratio_last = 8'((8'h01 << s.option[`WDT_OPT_PS_MSB:0]) - 8'h01);
    base_done = s.base_cnt == BASE_LAST;
    pend_any = |(irq_flags_i & irq_enables_i);
    pend_wake = |(irq_flags_i & irq_enables_i & SLEEP_WAKE_CAPABLE);
    sleep_go = sleep_instr_i & (s.st == RUN_ST) & ~pend_any;
    timeout = wdt_en & tick & base_done & (~prescaler_assign | s.post_cnt == ratio_last)
              & ~kick_watchdog_instr_i & ~sleep_go;
    idx = adr_i[15:2];
    bus_wr = cyc_i & stb_i & we_i & s.ack & sel_i[0];
    id_hit = idx[13:2] == 12'(`WDT_IDX_ID_BASE >> 2);
  end

  // ==========================================================
  // next state
  // ==========================================================
  always_comb begin
    next_s = s;
    next_s.osc_s1 = rc_osc_i;
    next_s.osc_s2 = s.osc_s1;
    next_s.osc_s3 = s.osc_s2;
    if (s.osc_s2 == s.osc_s3) begin
      next_s.osc_lvl = s.osc_s2;
    end
    next_s.osc_prev = s.osc_lvl;
    next_s.master_reset_pin_n_s1 = master_reset_pin_n_i;
    next_s.master_reset_pin_n_s2 = s.master_reset_pin_n_s1;
    next_s.master_reset_pin_n_s3 = s.master_reset_pin_n_s2;
    if (s.master_reset_pin_n_s2 == s.master_reset_pin_n_s3) begin
      next_s.master_reset_pin_n_lvl = s.master_reset_pin_n_s2;
    end
    next_s.dev_rst = 1'b0;
    next_s.wake = 1'b0;
    next_s.push = irq_taken_i;
    next_s.ack = cyc_i & stb_i & ~s.ack;
    next_s.verify_ok = prog_mode_i & s.fuse[`WDT_FUSE_CP0_BIT]
                       & s.fuse[`WDT_FUSE_CP1_BIT];
    // upper sixteen locations fold onto bank 0
    if (data_addr_i[6:0] >= `WDT_COMMON_BASE) begin
      next_s.phys = {2'b00, data_addr_i[6:0]};
    end else begin
      next_s.phys = data_addr_i;
    end

    // watchdog count on rc ticks, independent of sleep
    if (wdt_en && tick) begin
      if (base_done) begin
        next_s.base_cnt = '0;
        if (prescaler_assign) begin
          if (s.post_cnt == ratio_last) begin
            next_s.post_cnt = 8'h00;
          end else begin
            next_s.post_cnt = s.post_cnt + 8'h01;
          end
        end
      end else begin
        next_s.base_cnt = s.base_cnt + BW'(1);
      end
    end

    // register writes at the acknowledging edge
    if (bus_wr) begin
      if (idx == `WDT_IDX_OPTION) begin
        next_s.option = dat_i[7:0];
      end else if (idx == `WDT_IDX_FUSE && prog_mode_i) begin
        next_s.fuse = dat_i[7:0];
      end else if (id_hit && prog_mode_i) begin
        next_s.id[idx[1:0]] = dat_i[7:0];
      end
    end

    if (!s.master_reset_pin_n_lvl) begin
      // pin reset from any state, flags untouched
      next_s.dev_rst = 1'b1;
      next_s.st = RUN_ST;
      next_s.base_cnt = '0;
      next_s.post_cnt = 8'h00;
      next_s.option = `WDT_OPT_RESET;
    end else begin
      case (s.st)
        RUN_ST: begin
          if (timeout) begin
            next_s.dev_rst = 1'b1;
            next_s.to_n = 1'b0;
            next_s.pd_n = 1'b1;
            next_s.base_cnt = '0;
            next_s.post_cnt = 8'h00;
            next_s.option = `WDT_OPT_RESET;
          end else if (sleep_go) begin
            next_s.st = SLEEP_ST;
            next_s.to_n = 1'b1;
            next_s.pd_n = 1'b0;
            next_s.base_cnt = '0;
            next_s.post_cnt = 8'h00;
          end else if (kick_watchdog_instr_i) begin
            // assignment bit kept, only counts cleared
            next_s.base_cnt = '0;
            next_s.post_cnt = 8'h00;
          end
        end
        SLEEP_ST: begin
          if (timeout) begin
            next_s.st = RUN_ST;
            next_s.wake = 1'b1;
            next_s.vector = 1'b0;
            next_s.to_n = 1'b0;
          end else if (pend_wake) begin
            // sleep effects already done on entry
            next_s.st = RUN_ST;
            next_s.wake = 1'b1;
            next_s.vector = global_irq_enable_i;
          end
        end
        default: begin
          next_s.st = RUN_ST;
        end
      endcase
    end

    // read data captured with the acknowledge
    if (cyc_i && stb_i && !s.ack && !we_i) begin
      next_s.dat = 32'h0000_0000;
      if (idx == `WDT_IDX_OPTION) begin
        next_s.dat[7:0] = s.option;
      end else if (idx == `WDT_IDX_FUSE) begin
        next_s.dat[7:0] = s.fuse;
      end else if (idx == `WDT_IDX_STATUS) begin
        next_s.dat[`WDT_STAT_TO_BIT] = s.to_n;
        next_s.dat[`WDT_STAT_PD_BIT] = s.pd_n;
      end else if (id_hit && prog_mode_i) begin
        next_s.dat[7:0] = s.id[idx[1:0]];
      end
    end

    if (rst_i) begin
      next_s = '0;
      next_s.st = RUN_ST;
      next_s.master_reset_pin_n_s1 = 1'b1;
      next_s.master_reset_pin_n_s2 = 1'b1;
      next_s.master_reset_pin_n_s3 = 1'b1;
      next_s.master_reset_pin_n_lvl = 1'b1;
      next_s.to_n = 1'b1;
      next_s.pd_n = 1'b1;
      next_s.option = `WDT_OPT_RESET;
      next_s.fuse = `WDT_FUSE_RESET;
    end
  end

  always_ff @(posedge clk_i) begin
    s <= next_s;
  end

  // ==========================================================
  // outputs
  // ==========================================================
  always_comb begin
    ack_o = s.ack;
    dat_o = s.dat;
    device_reset_o = s.dev_rst;
    wake_o = s.wake;
    vector_after_wake_o = s.vector;
    osc_drive_en_o = s.st == RUN_ST;
    io_hold_o = s.st == SLEEP_ST;
    power_state_o = s.st;
    stack_push_o = s.push;
    data_phys_o = s.phys;
    watchdog_expired_flag_n_o = s.to_n;
    sleep_entered_flag_n_o = s.pd_n;
    verify_read_allowed_o = s.verify_ok;
    debug_enabled_o = ~s.fuse[`WDT_FUSE_DEBUG_BIT];
    stack_levels_o = s.fuse[`WDT_FUSE_DEBUG_BIT] ? `WDT_STACK_LEVELS
                     : `WDT_STACK_LEVELS_DEBUG;
  end

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence seq_asleep_ok;
    s.st == SLEEP_ST && s.master_reset_pin_n_lvl;
  endsequence

  sequence seq_run_ok;
    s.st == RUN_ST && s.master_reset_pin_n_lvl;
  endsequence

  a_kick_clears_count: assert property (
    seq_run_ok ##0 kick_watchdog_instr_i |=> s.base_cnt == '0
      && s.post_cnt == 8'h00)
    else $error("kick did not clear watchdog");

  a_fuse_off_idle: assert property (
    (!wdt_en && s.master_reset_pin_n_lvl && !kick_watchdog_instr_i && !sleep_instr_i) [*2]
      |-> s.base_cnt == $past(s.base_cnt) && !device_reset_o)
    else $error("watchdog ran while disabled");

  a_sleep_entry_flags: assert property (
    seq_run_ok ##0 sleep_go |=> !s.pd_n && s.to_n && !osc_drive_en_o
      && io_hold_o && s.base_cnt == '0)
    else $error("sleep entry effects wrong");

  a_sleep_as_nop: assert property (
    seq_run_ok ##0 sleep_instr_i && pend_any && !timeout |=>
      s.st == RUN_ST && $stable(s.pd_n) && $stable(s.to_n))
    else $error("pending sleep not a no-op");

  a_run_timeout_rst: assert property (
    seq_run_ok ##0 timeout |=> device_reset_o && !s.to_n && s.pd_n
      && s.option == `WDT_OPT_RESET)
    else $error("run timeout did not reset");

  a_sleep_timeout_wake: assert property (
    seq_asleep_ok ##0 timeout |=> wake_o && !device_reset_o
      && !s.to_n && !s.pd_n && s.st == RUN_ST)
    else $error("sleep timeout did not wake");

  a_irq_wake_vector: assert property (
    seq_asleep_ok ##0 pend_wake && !timeout |=> wake_o && s.to_n
      && vector_after_wake_o == $past(global_irq_enable_i))
    else $error("interrupt wake wrong");

  a_option_kept_kick: assert property (
    kick_watchdog_instr_i && !bus_wr && !timeout && s.master_reset_pin_n_lvl
      |=> $stable(s.option))
    else $error("kick changed assignment");

  a_common_bank_map: assert property (
    data_addr_i[6:0] >= `WDT_COMMON_BASE |=>
      data_phys_o == {2'b00, $past(data_addr_i[6:0])})
    else $error("common area not shared");

  a_push_on_irq: assert property (
    irq_taken_i |=> stack_push_o ##1 !$past(irq_taken_i) || stack_push_o)
    else $error("return push missing");

  a_id_locked: assert property (
    cyc_i && stb_i && !we_i && !s.ack && id_hit && !prog_mode_i
      |=> ack_o && dat_o == 32'h0000_0000)
    else $error("id word readable outside program mode");

endmodule
`default_nettype wire

// file: dv/cpu_side_model.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_side_model (
  input wire logic clk_i,
  output logic rc_osc_o,
  output logic kick_o,
  output logic sleep_o,
  output logic taken_o
);
  int div = 0;
  initial begin
    rc_osc_o = 0;
    {taken_o, sleep_o, kick_o} = 3'b000;
  end
  // ==========================================
  // rc oscillator, free running also in sleep
  always @(posedge clk_i) begin
    div <= (div == 4) ? 0 : div + 1;
    if (div == 4) rc_osc_o <= ~rc_osc_o;
  end
  // ==========================================
  // one-cycle pulses: 0 kick, 1 sleep, 2 taken
  task pulse(input int k);
    @(posedge clk_i);
    {taken_o, sleep_o, kick_o} <= 3'(1 << k);
    @(posedge clk_i);
    {taken_o, sleep_o, kick_o} <= 3'b000;
  endtask
endmodule
`default_nettype wire

// file: dv/watchdog_sleep_wake_control_test.sv
`timescale 1ns/100ps
`default_nettype none
module watchdog_sleep_wake_control_test;
  import wdt_types_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, pin_n = 1;
  logic pm = 0, global_irq_enable = 0, live = 0, rc, kick, slp, taken;
  logic [15:0] adr = '0;
  logic [31:0] wdat = '0, dat_o;
  logic [7:0] flg = '0, ena = '0;
  logic [8:0] da = '0, last_da = '0, phys;
  logic ack_o, rst_o, wake_o, vec, osc, hold, push, to_n, pd_n, vfy, dbg;
  logic [3:0] lvl;
  logic [3:0] sel = 4'hF;
  power_state_type pst;
  logic [15:0] rq[$];
  int fails = 0, n_compared = 0, cyc_n = 0, n_rst = 0, n_wake = 0;
  int seed = 32'h7FBE5EA0;
  always #25 clk_i = ~clk_i;
  cpu_side_model m (.clk_i(clk_i), .rc_osc_o(rc), .kick_o(kick),
    .sleep_o(slp), .taken_o(taken));
  watchdog_sleep_wake_control #(.WDT_BASE_TICKS(4)) dut (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
    .rc_osc_i(rc), .master_reset_pin_n_i(pin_n),
    .kick_watchdog_instr_i(kick), .sleep_instr_i(slp),
    .irq_taken_i(taken), .irq_flags_i(flg), .irq_enables_i(ena),
    .global_irq_enable_i(global_irq_enable), .prog_mode_i(pm), .data_addr_i(da),
    .device_reset_o(rst_o), .wake_o(wake_o), .vector_after_wake_o(vec),
    .osc_drive_en_o(osc), .io_hold_o(hold), .power_state_o(pst),
    .stack_push_o(push), .data_phys_o(phys),
    .watchdog_expired_flag_n_o(to_n), .sleep_entered_flag_n_o(pd_n),
    .verify_read_allowed_o(vfy), .debug_enabled_o(dbg),
    .stack_levels_o(lvl));
  // ==========================================
  // helpers
  task report_and_stop;
    if (fails == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    n_compared++;
    if (seen !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task bus(input logic w, input logic [15:0] a, input logic [7:0] d,
    input logic [7:0] mk);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= {24'($random(seed)), d};
    sel <= {3'($random(seed)), 1'b1};
    if (!w) rq.push_back({mk, d});
    @(negedge clk_i);
    while (ack_o !== 1'b1) @(negedge clk_i);
    @(posedge clk_i);
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask
  task wait_for(input int w, input int tgt);
    for (int i = 0; i < 600 && (w ? n_wake : n_rst) < tgt; i++)
      @(negedge clk_i);
  endtask
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n > 6000) begin
      fails++;
      report_and_stop();
    end
    if (ack_o === 1'b1 && !we && rq.size() > 0) begin
      chk("rd", dat_o & {24'h0, rq[0][15:8]}, {24'h0, rq[0][7:0]});
      void'(rq.pop_front());
    end
    if (rst_o === 1'b1) n_rst++;
    if (wake_o === 1'b1) n_wake++;
    if (live)
      chk("phys", phys, last_da[6:0] >= 7'h70 ? {2'b00, last_da[6:0]} : last_da);
    last_da <= da;
    da <= 9'($random(seed));
    live <= !rst_i;
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    bus(0, 16'h0204, 8'hFF, 8'hFF);
    bus(0, 16'h801C, 8'hFF, 8'hFF);
    bus(0, 16'h000C, 8'h18, 8'h18);
    bus(0, {2'b01, 12'($random(seed)), 2'b00}, 8'h00, 8'hFF);
    bus(0, 16'h8000, 8'h00, 8'hFF);
    pm <= 1;
    bus(1, 16'h8000, 8'h0A, 8'h00);
    bus(0, 16'h8000, 8'h0A, 8'h0F);
    pm <= 0;
    flg <= 8'h01;
    ena <= 8'h01;
    m.pulse(1);
    repeat (3) @(negedge clk_i);
    chk("noop", pst, RUN_ST);
    bus(0, 16'h000C, 8'h18, 8'h18);
    flg <= 0;
    global_irq_enable <= 1'($random(seed));
    m.pulse(2);
    @(negedge clk_i);
    chk("push", push, 1);
    m.pulse(1);
    @(negedge clk_i);
    chk("sleep", {osc, hold, pst}, 3'b011);
    chk("flags", {to_n, pd_n}, 2'b10);
    bus(0, 16'h000C, 8'h10, 8'h18);
    flg <= 8'h08;
    repeat (20) @(negedge clk_i);
    chk("nowake", n_wake, 0);
    @(posedge clk_i);
    ena <= 8'h08;
    wait_for(1, 1);
    @(negedge clk_i);
    chk("vec", {vec, osc}, {global_irq_enable, 1'b1});
    @(posedge clk_i);
    flg <= 8'($random(seed)) & 8'h0F;
    ena <= 8'($random(seed)) & 8'hF0;
    m.pulse(0);
    bus(1, 16'h0204, 8'h08, 8'h00);
    repeat (10) begin
      repeat (15) @(posedge clk_i);
      m.pulse(0);
    end
    bus(0, 16'h0204, 8'h08, 8'hFF);
    chk("kick", n_rst, 0);
    wait_for(0, 1);
    chk("wrst", n_rst, 1);
    chk("rflags", {to_n, pd_n}, 2'b01);
    bus(0, 16'h000C, 8'h08, 8'h18);
    bus(0, 16'h0204, 8'hFF, 8'hFF);
    m.pulse(0);
    bus(1, 16'h0204, 8'h08, 8'h00);
    m.pulse(1);
    wait_for(1, 2);
    chk("wwake", n_wake, 2);
    chk("wnorst", n_rst, 1);
    chk("wflags", {to_n, pd_n}, 2'b00);
    bus(0, 16'h000C, 8'h00, 8'h18);
    chk("vec0", vec, 0);
    m.pulse(0);
    pm <= 1;
    bus(1, 16'h801C, 8'h7B, 8'h00);
    repeat (2) @(negedge clk_i);
    chk("dbg", {dbg, lvl, vfy}, {1'b1, 4'h7, 1'b1});
    @(posedge clk_i);
    pm <= 0;
    repeat (300) @(negedge clk_i);
    chk("off", n_rst, 1);
    chk("vfy", vfy, 0);
    @(posedge clk_i);
    pin_n <= 0;
    wait_for(0, 2);
    @(posedge clk_i);
    pin_n <= 1;
    chk("pin", n_rst > 1, 1);
    report_and_stop();
  end
endmodule
`default_nettype wire
